// file: rtl/blanking_pkg.sv
// Purpose: Shared constants for the comparator blanking mask logic
// Assumes: 32-bit Avalon-MM register bus, 16-bit registers in the low half
// Notes:   Source codes index a sixteen-wide source vector
package blanking_pkg;

  // Register byte offsets
  localparam logic [3:0] SRC_SELECT_OFFSET  = 4'h0;
  localparam logic [3:0] GATE_CONTROL_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET      = 4'h8;

  // Widths
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned REG_WIDTH  = 16;
  localparam int unsigned SEL_WIDTH  = 4;
  localparam int unsigned SRC_COUNT  = 16;
  localparam int unsigned PWM_COUNT  = 6;

  // Reset values
  localparam logic [15:0] SRC_SELECT_RESET   = 16'h0000;
  localparam logic [15:0] GATE_CONTROL_RESET = 16'h0000;

  // Writable bits; the rest read as zero
  localparam logic [15:0] SRC_SELECT_MASK   = 16'h0FFF;
  localparam logic [15:0] GATE_CONTROL_MASK = 16'hBFFF;

  // Source select field positions
  localparam int unsigned SEL_A_LSB = 0;
  localparam int unsigned SEL_B_LSB = 4;
  localparam int unsigned SEL_C_LSB = 8;

  // Gate control bit positions
  localparam int unsigned LEVEL_SELECT_BIT   = 15;
  localparam int unsigned OR_C_TRUE_BIT      = 13;
  localparam int unsigned OR_C_INV_BIT       = 12;
  localparam int unsigned OR_B_TRUE_BIT      = 11;
  localparam int unsigned OR_B_INV_BIT       = 10;
  localparam int unsigned OR_A_TRUE_BIT      = 9;
  localparam int unsigned OR_A_INV_BIT       = 8;
  localparam int unsigned AND_INV_TO_OR_BIT  = 7;
  localparam int unsigned AND_TRUE_TO_OR_BIT = 6;
  localparam int unsigned AND_C_TRUE_BIT     = 5;
  localparam int unsigned AND_C_INV_BIT      = 4;
  localparam int unsigned AND_B_TRUE_BIT     = 3;
  localparam int unsigned AND_B_INV_BIT      = 2;
  localparam int unsigned AND_A_TRUE_BIT     = 1;
  localparam int unsigned AND_A_INV_BIT      = 0;

  // Status register bit positions
  localparam int unsigned ST_MASK_A_BIT  = 0;
  localparam int unsigned ST_MASK_B_BIT  = 1;
  localparam int unsigned ST_MASK_C_BIT  = 2;
  localparam int unsigned ST_AND_BIT     = 3;
  localparam int unsigned ST_WINDOW_BIT  = 4;
  localparam int unsigned ST_CMP_IN_BIT  = 5;
  localparam int unsigned ST_CMP_OUT_BIT = 6;

  // Source vector positions above the PWM pairs
  localparam int unsigned SRC_TRIG18_IDX = 12;
  localparam int unsigned SRC_TRIG19_IDX = 13;
  localparam int unsigned SRC_FAULT2_IDX = 14;
  localparam int unsigned SRC_FAULT4_IDX = 15;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_e;

endpackage : blanking_pkg

// file: rtl/mask_source_mux.sv
// Purpose: Sixteen-way picker for one mask input
// Assumes: Sources are synchronous to the core clock
// Notes:   Purely combinational; the top registers its results
`timescale 1ns/1ps
module mask_source_mux
  import blanking_pkg::*;
(
  // Sources and select
  input  wire logic [SRC_COUNT-1:0] sources_i,
  input  wire logic [SEL_WIDTH-1:0] select_i,
  // Picked source
  output logic                      mask_o
);

  assign mask_o = sources_i[select_i];

endmodule // mask_source_mux

// file: rtl/comparator_blanking.sv
// Purpose: Blanking mask logic for a comparator output, with its registers
// Assumes: Mask sources and comparator are logic on core_clk_i
// Notes:   Registers sit on an Avalon-MM slave with one wait cycle
//
// How it works
// - Mask A code picks PWM, trigger, fault
// - Level one blocks low-asserted comparator
// - Level zero blocks high-asserted comparator
// - Gate control bit 14 reads zero
// - Bit 13 puts mask C into OR
// - Bit 12 puts inverted C into OR
// - Bit 11 puts mask B into OR
// - Bit 10 puts inverted B into OR
// - Bit 9 puts mask A into OR
// - Bit 8 puts inverted A into OR
// - Bit 7 puts inverted AND into OR
// - Bit 6 puts AND result into OR
// - Bit 5 puts mask C into AND
// - Bit 4 puts inverted C into AND
// - Bit 3 puts mask B into AND
// - Bit 2 puts inverted B into AND
// - Bit 1 puts mask A into AND
// - Bit 0 puts inverted A into AND
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module comparator_blanking
  import blanking_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  // Avalon-MM slave
  input  wire logic [ADDR_WIDTH-1:0] address_i,
  input  wire logic                  read_i,
  input  wire logic                  write_i,
  input  wire logic [3:0]            byteenable_i,
  input  wire logic [DATA_WIDTH-1:0] writedata_i,
  output logic      [DATA_WIDTH-1:0] readdata_o,
  output logic                       waitrequest_o,
  // Mask sources
  input  wire logic [PWM_COUNT-1:0]  pwm_high_i,
  input  wire logic [PWM_COUNT-1:0]  pwm_low_i,
  input  wire logic                  trigger_output_18_i,
  input  wire logic                  trigger_output_19_i,
  input  wire logic                  fault_input_2_i,
  input  wire logic                  fault_input_4_i,
  // Comparator path
  input  wire logic                  comparator_i,
  output logic                       blanked_comparator_o,
  output logic                       blanking_window_o
);

  // Registers
  logic [REG_WIDTH-1:0] blanking_source_select;
  logic [REG_WIDTH-1:0] blanking_gate_control;
  bus_state_e           bus_state;
  bus_state_e           next_bus_state;

  // Bus decode
  logic                  request;
  logic                  accept;
  logic                  hit_source;
  logic                  hit_gate;
  logic                  hit_status;
  logic [REG_WIDTH-1:0]  lane_mask;
  logic [REG_WIDTH-1:0]  next_source_select;
  logic [REG_WIDTH-1:0]  next_gate_control;
  logic [REG_WIDTH-1:0]  read_word;
  logic [DATA_WIDTH-1:0] next_readdata;

  // Mask path
  logic [SRC_COUNT-1:0] sources;
  logic                 mask_a_input;
  logic                 mask_b_input;
  logic                 mask_c_input;
  logic                 and_gate_result;
  logic                 or_gate_result;
  logic                 next_blanked;
  logic [REG_WIDTH-1:0] status_word;

  // Gate control fields
  logic masking_level_select;
  logic or_c_true_enable;
  logic or_c_inverted_enable;
  logic or_b_true_enable;
  logic or_b_inverted_enable;
  logic or_a_true_enable;
  logic or_a_inverted_enable;
  logic and_result_inverted_to_or;
  logic and_result_true_to_or;
  logic and_c_true_enable;
  logic and_c_inverted_enable;
  logic and_b_true_enable;
  logic and_b_inverted_enable;
  logic and_a_true_enable;
  logic and_a_inverted_enable;
  logic any_and_enable;

  // Gate terms; a disabled term is one in AND, zero in OR
  logic and_a_true_term;
  logic and_a_inv_term;
  logic and_b_true_term;
  logic and_b_inv_term;
  logic and_c_true_term;
  logic and_c_inv_term;
  logic or_a_true_term;
  logic or_a_inv_term;
  logic or_b_true_term;
  logic or_b_inv_term;
  logic or_c_true_term;
  logic or_c_inv_term;
  logic and_true_term;
  logic and_inv_term;

  // Field slicing
  assign masking_level_select      = blanking_gate_control[LEVEL_SELECT_BIT];
  assign or_c_true_enable          = blanking_gate_control[OR_C_TRUE_BIT];
  assign or_c_inverted_enable      = blanking_gate_control[OR_C_INV_BIT];
  assign or_b_true_enable          = blanking_gate_control[OR_B_TRUE_BIT];
  assign or_b_inverted_enable      = blanking_gate_control[OR_B_INV_BIT];
  assign or_a_true_enable          = blanking_gate_control[OR_A_TRUE_BIT];
  assign or_a_inverted_enable      = blanking_gate_control[OR_A_INV_BIT];
  assign and_result_inverted_to_or = blanking_gate_control[AND_INV_TO_OR_BIT];
  assign and_result_true_to_or     = blanking_gate_control[AND_TRUE_TO_OR_BIT];
  assign and_c_true_enable         = blanking_gate_control[AND_C_TRUE_BIT];
  assign and_c_inverted_enable     = blanking_gate_control[AND_C_INV_BIT];
  assign and_b_true_enable         = blanking_gate_control[AND_B_TRUE_BIT];
  assign and_b_inverted_enable     = blanking_gate_control[AND_B_INV_BIT];
  assign and_a_true_enable         = blanking_gate_control[AND_A_TRUE_BIT];
  assign and_a_inverted_enable     = blanking_gate_control[AND_A_INV_BIT];

  // Source vector: even codes low side, odd codes high side of each PWM
  // source code order
  genvar g;
  generate
    for (g = 0; g < PWM_COUNT; g = g + 1) begin : g_pwm
      assign sources[2*g]   = pwm_low_i[g];
      assign sources[2*g+1] = pwm_high_i[g];
    end
  endgenerate
  assign sources[SRC_TRIG18_IDX] = trigger_output_18_i;
  assign sources[SRC_TRIG19_IDX] = trigger_output_19_i;
  assign sources[SRC_FAULT2_IDX] = fault_input_2_i;
  assign sources[SRC_FAULT4_IDX] = fault_input_4_i;

  mask_source_mux u_mux_a (
    .sources_i (sources),
    .select_i  (blanking_source_select[SEL_A_LSB +: SEL_WIDTH]),
    .mask_o    (mask_a_input)
  );

  mask_source_mux u_mux_b (
    .sources_i (sources),
    .select_i  (blanking_source_select[SEL_B_LSB +: SEL_WIDTH]),
    .mask_o    (mask_b_input)
  );

  mask_source_mux u_mux_c (
    .sources_i (sources),
    .select_i  (blanking_source_select[SEL_C_LSB +: SEL_WIDTH]),
    .mask_o    (mask_c_input)
  );

  // Disabled AND terms read as one; an AND with no terms gives zero
  // so that an unconfigured gate opens a window only through bit 7, the inverted path
  assign any_and_enable = and_a_true_enable | and_a_inverted_enable
                        | and_b_true_enable | and_b_inverted_enable
                        | and_c_true_enable | and_c_inverted_enable;

  assign and_a_true_term = ~and_a_true_enable | mask_a_input;
  assign and_a_inv_term  = ~and_a_inverted_enable | ~mask_a_input;
  assign and_b_true_term = ~and_b_true_enable | mask_b_input;
  assign and_b_inv_term  = ~and_b_inverted_enable | ~mask_b_input;
  assign and_c_true_term = ~and_c_true_enable | mask_c_input;
  assign and_c_inv_term  = ~and_c_inverted_enable | ~mask_c_input;
  // True and inverted of one mask together force zero
  assign and_gate_result = any_and_enable
                         & and_a_true_term & and_a_inv_term
                         & and_b_true_term & and_b_inv_term
                         & and_c_true_term & and_c_inv_term;

  assign or_a_true_term = or_a_true_enable & mask_a_input;
  assign or_a_inv_term  = or_a_inverted_enable & ~mask_a_input;
  assign or_b_true_term = or_b_true_enable & mask_b_input;
  assign or_b_inv_term  = or_b_inverted_enable & ~mask_b_input;
  assign or_c_true_term = or_c_true_enable & mask_c_input;
  assign or_c_inv_term  = or_c_inverted_enable & ~mask_c_input;
  assign and_true_term  = and_result_true_to_or & and_gate_result;
  assign and_inv_term   = and_result_inverted_to_or & ~and_gate_result;
  assign or_gate_result = or_a_true_term | or_a_inv_term
                        | or_b_true_term | or_b_inv_term
                        | or_c_true_term | or_c_inv_term
                        | and_true_term  | and_inv_term;

  assign next_blanked = masking_level_select ? (comparator_i | or_gate_result)
                                             : (comparator_i & ~or_gate_result);

  // Status view of the live mask path; unused bits read zero
  assign status_word[REG_WIDTH-1:ST_CMP_OUT_BIT+1] = '0;
  assign status_word[ST_CMP_OUT_BIT]              = blanked_comparator_o;
  assign status_word[ST_CMP_IN_BIT]               = comparator_i;
  assign status_word[ST_WINDOW_BIT]               = or_gate_result;
  assign status_word[ST_AND_BIT]                  = and_gate_result;
  assign status_word[ST_MASK_C_BIT]               = mask_c_input;
  assign status_word[ST_MASK_B_BIT]               = mask_b_input;
  assign status_word[ST_MASK_A_BIT]               = mask_a_input;

  // Bus decode; one wait cycle lets read data come from a flop
  assign request    = read_i | write_i;
  // Writes land on the edge that sees waitrequest low
  assign accept     = (bus_state == BUS_ANSWER) & request;
  assign hit_source = (address_i == SRC_SELECT_OFFSET);
  assign hit_gate   = (address_i == GATE_CONTROL_OFFSET);
  assign hit_status = (address_i == STATUS_OFFSET);
  // Lanes 3 and 2 have no bits behind them
  assign lane_mask  = {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  // Bus state step; the answer lasts exactly one cycle
  always_comb begin
    case (bus_state)
      BUS_IDLE:   next_bus_state = request ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: next_bus_state = BUS_IDLE;
      default:    next_bus_state = BUS_IDLE;
    endcase
  end

  // unimplemented bits stay zero on write
  assign next_source_select = (accept && write_i && hit_source)
    ? (((blanking_source_select & ~lane_mask) | (writedata_i[REG_WIDTH-1:0] & lane_mask))
       & SRC_SELECT_MASK)
    : blanking_source_select;
  assign next_gate_control = (accept && write_i && hit_gate)
    ? (((blanking_gate_control & ~lane_mask) | (writedata_i[REG_WIDTH-1:0] & lane_mask))
       & GATE_CONTROL_MASK)
    : blanking_gate_control;

  // read back masked; unmapped reads zero
  assign read_word = hit_source ? (blanking_source_select & SRC_SELECT_MASK)
                   : hit_gate   ? (blanking_gate_control & GATE_CONTROL_MASK)
                   : hit_status ? status_word
                   : '0;
  // Status reads are a snapshot taken as the read is seen
  assign next_readdata = (bus_state == BUS_IDLE && read_i) ? {16'h0000, read_word}
                                                           : readdata_o;

  // Bus handshake
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state     <= BUS_IDLE;
      waitrequest_o <= 1'b1;
      readdata_o    <= 32'h0000_0000;
    end else begin
      bus_state     <= next_bus_state;
      waitrequest_o <= (next_bus_state != BUS_ANSWER);
      readdata_o    <= next_readdata;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blanking_source_select <= SRC_SELECT_RESET;
      blanking_gate_control  <= GATE_CONTROL_RESET;
    end else begin
      blanking_source_select <= next_source_select;
      blanking_gate_control  <= next_gate_control;
    end
  end

  // Output stage; one cycle from comparator to pin
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blanked_comparator_o <= 1'b0;
      blanking_window_o    <= 1'b0;
    end else begin
      blanked_comparator_o <= next_blanked;
      blanking_window_o    <= or_gate_result;
    end
  end

endmodule // comparator_blanking

// file: bench/blanking_sources_model.sv
// Purpose: Far-side model of the PWM, trigger and fault source levels
// Assumes: All sources are plain levels on the core clock
// Notes:   Pattern bit n appears on source code n one edge later
`timescale 1ns/1ps
module blanking_sources_model
  import blanking_pkg::*;
(
  // Clock and requested levels
  input  wire logic                 core_clk_i,
  input  wire logic [SRC_COUNT-1:0] pattern_i,
  // Source levels
  output logic      [PWM_COUNT-1:0] pwm_high_o,
  output logic      [PWM_COUNT-1:0] pwm_low_o,
  output logic                      trigger_18_o,
  output logic                      trigger_19_o,
  output logic                      fault_2_o,
  output logic                      fault_4_o
);
  logic [SRC_COUNT-1:0] level;
  always_ff @(posedge core_clk_i) begin
    level <= pattern_i;
  end
  always_comb begin
    for (int n = 0; n < PWM_COUNT; n++) begin
      pwm_low_o[n]  = level[2*n];
      pwm_high_o[n] = level[2*n+1];
    end
  end
  assign trigger_18_o = level[SRC_TRIG18_IDX];
  assign trigger_19_o = level[SRC_TRIG19_IDX];
  assign fault_2_o    = level[SRC_FAULT2_IDX];
  assign fault_4_o    = level[SRC_FAULT4_IDX];
endmodule // blanking_sources_model

// file: bench/comparator_blanking_props.sv
// Purpose: Port assertions for the comparator blanking block
// Assumes: Shadow registers follow writes committed on the bus
// Notes:   Outputs lag their cause by one edge
`timescale 1ns/1ps
module comparator_blanking_props
  import blanking_pkg::*;
(
  // Clock, reset and bus
  input wire logic                  core_clk_i,
  input wire logic                  rst_n_i,
  input wire logic [ADDR_WIDTH-1:0] address_i,
  input wire logic                  read_i,
  input wire logic                  write_i,
  input wire logic [3:0]            byteenable_i,
  input wire logic [DATA_WIDTH-1:0] writedata_i,
  input wire logic [DATA_WIDTH-1:0] readdata_o,
  input wire logic                  waitrequest_o,
  // Sources and comparator
  input wire logic [PWM_COUNT-1:0]  pwm_high_i,
  input wire logic [PWM_COUNT-1:0]  pwm_low_i,
  input wire logic                  trigger_output_18_i,
  input wire logic                  trigger_output_19_i,
  input wire logic                  fault_input_2_i,
  input wire logic                  fault_input_4_i,
  input wire logic                  comparator_i,
  input wire logic                  blanked_comparator_o,
  input wire logic                  blanking_window_o
);
  logic [15:0] sel;
  logic [15:0] gc;
  wire logic [15:0] srcv = {fault_input_4_i, fault_input_2_i, trigger_output_19_i,
    trigger_output_18_i, pwm_high_i[5], pwm_low_i[5], pwm_high_i[4], pwm_low_i[4],
    pwm_high_i[3], pwm_low_i[3], pwm_high_i[2], pwm_low_i[2], pwm_high_i[1],
    pwm_low_i[1], pwm_high_i[0], pwm_low_i[0]};
  wire logic       ma      = srcv[sel[3:0]];
  wire logic       mb      = srcv[sel[7:4]];
  wire logic       mc      = srcv[sel[11:8]];
  wire logic [5:0] terms   = {mc, ~mc, mb, ~mb, ma, ~ma};
  wire logic       and_res = (|gc[5:0]) & (&(terms | ~gc[5:0]));
  wire logic       exp_or  = |({terms, ~and_res, and_res} & gc[13:6]);
  wire logic       commit  = write_i & ~waitrequest_o;
  wire logic [15:0] wd     = writedata_i[15:0];
  wire logic [15:0] new_sel = {byteenable_i[1] ? wd[15:8] : sel[15:8],
                               byteenable_i[0] ? wd[7:0] : sel[7:0]};
  wire logic [15:0] new_gc  = {byteenable_i[1] ? wd[15:8] : gc[15:8],
                               byteenable_i[0] ? wd[7:0] : gc[7:0]};
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel <= 16'h0000;
      gc  <= 16'h0000;
    end else if (commit && address_i == SRC_SELECT_OFFSET) begin
      sel <= new_sel & SRC_SELECT_MASK;
    end else if (commit && address_i == GATE_CONTROL_OFFSET) begin
      gc <= new_gc & GATE_CONTROL_MASK;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_taken; (read_i || write_i) && waitrequest_o; endsequence
  sequence s_answer; !waitrequest_o ##1 waitrequest_o; endsequence
  property p_one_wait; s_taken |=> s_answer; endproperty
  property p_window; blanking_window_o == $past(exp_or); endproperty
  property p_no_or; gc[13:6] == 8'h00 |=> !blanking_window_o; endproperty
  property p_and_a; (gc[13:0] == 14'h0042 || gc[13:0] == 14'h0041)
    |=> blanking_window_o == ($past(ma) ~^ $past(gc[1])); endproperty
  property p_nand_empty; gc[13:0] == 14'h0080 |=> blanking_window_o; endproperty
  property p_level_high; gc[15]
    |=> blanked_comparator_o == ($past(comparator_i) | blanking_window_o); endproperty
  property p_level_low; !gc[15]
    |=> blanked_comparator_o == ($past(comparator_i) & !blanking_window_o); endproperty
  property p_readback; read_i && !waitrequest_o && address_i != STATUS_OFFSET
    |-> readdata_o == {16'h0000, address_i == GATE_CONTROL_OFFSET ? gc :
                       address_i == SRC_SELECT_OFFSET ? sel : 16'h0000}; endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not exactly one cycle");
  a_window: assert property (p_window)
    else $error("window differs from gate combination");
  a_no_or: assert property (p_no_or)
    else $error("window with no OR inputs");
  a_and_a: assert property (p_and_a)
    else $error("single AND term wrong");
  a_nand_empty: assert property (p_nand_empty)
    else $error("empty AND not low");
  a_level_high: assert property (p_level_high)
    else $error("low-asserted output not blanked");
  a_level_low: assert property (p_level_low)
    else $error("high-asserted output not blanked");
  a_readback: assert property (p_readback)
    else $error("register readback wrong");
endmodule // comparator_blanking_props
bind comparator_blanking comparator_blanking_props comparator_blanking_props_i (
  .core_clk_i, .rst_n_i, .address_i, .read_i, .write_i, .byteenable_i, .writedata_i,
  .readdata_o, .waitrequest_o, .pwm_high_i, .pwm_low_i, .trigger_output_18_i,
  .trigger_output_19_i, .fault_input_2_i, .fault_input_4_i, .comparator_i,
  .blanked_comparator_o, .blanking_window_o
);

// file: bench/test_comparator_blanking.sv
// Purpose: Self-checking bench for the comparator blanking block
// Assumes: One wait cycle per bus access, outputs one edge after cause
// Notes:   Random configurations from a fixed xorshift seed
`timescale 1ns/1ps
module test_comparator_blanking
  import blanking_pkg::*;
;
  logic                  core_clk_i   = 1'b0;
  logic                  rst_n_i      = 1'b0;
  logic [ADDR_WIDTH-1:0] address_i    = 4'h0;
  logic                  read_i       = 1'b0;
  logic                  write_i      = 1'b0;
  logic [3:0]            byteenable_i = 4'h0;
  logic [DATA_WIDTH-1:0] writedata_i  = 32'h0000_0000;
  logic [15:0]           pattern      = 16'h0000;
  logic                  comparator_i = 1'b0;
  logic [31:0]           rng          = 32'h0000_6B19;
  int                    n_errors     = 0;
  int                    tests_run    = 0;
  wire logic [DATA_WIDTH-1:0] readdata_o;
  wire logic waitrequest_o, blanked_comparator_o, blanking_window_o;
  wire logic [PWM_COUNT-1:0] pwm_high_i, pwm_low_i;
  wire logic trigger_output_18_i, trigger_output_19_i, fault_input_2_i, fault_input_4_i;
  logic [15:0] corners [8] = '{16'h0000, 16'h8000, 16'h0080, 16'h0042, 16'h8041,
                               16'h0043, 16'h3F00, 16'hFFFF};

  comparator_blanking comparator_blanking_i (.core_clk_i, .rst_n_i, .address_i, .read_i,
    .write_i, .byteenable_i, .writedata_i, .readdata_o, .waitrequest_o, .pwm_high_i,
    .pwm_low_i, .trigger_output_18_i, .trigger_output_19_i, .fault_input_2_i,
    .fault_input_4_i, .comparator_i, .blanked_comparator_o, .blanking_window_o);
  blanking_sources_model blanking_sources_model_i (.core_clk_i, .pattern_i(pattern),
    .pwm_high_o(pwm_high_i), .pwm_low_o(pwm_low_i), .trigger_18_o(trigger_output_18_i),
    .trigger_19_o(trigger_output_19_i), .fault_2_o(fault_input_2_i),
    .fault_4_o(fault_input_4_i));

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [6:0] expect_out(input logic [15:0] s, g, p, input logic c);
    logic [5:0] t;
    logic a, o;
    t = {p[s[11:8]], ~p[s[11:8]], p[s[7:4]], ~p[s[7:4]], p[s[3:0]], ~p[s[3:0]]};
    a = (|g[5:0]) & (&(t | ~g[5:0]));
    o = |({t, ~a, a} & g[13:6]);
    // Status order: output, comparator, window, AND, masks C B A
    return {g[15] ? (c | o) : (c & ~o), c, o, a, t[5], t[3], t[1]};
  endfunction

  task automatic chk_reg(input string name, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk_pin(input string name, input logic [1:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", name, e, g);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, be, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge core_clk_i);
    address_i    <= a;
    byteenable_i <= be;
    writedata_i  <= d;
    read_i       <= !wr;
    write_i      <= wr;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    q = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
    if (n >= 20) chk_reg("waitrequest", 32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic apply(input logic [15:0] s, g, p, input logic c);
    logic [31:0] q;
    logic [6:0]  e;
    e = expect_out(s & SRC_SELECT_MASK, g & GATE_CONTROL_MASK, p, c);
    bus(1'b1, SRC_SELECT_OFFSET, 4'h3, {16'h0000, s}, q);
    bus(1'b1, GATE_CONTROL_OFFSET, 4'h3, {16'h0000, g}, q);
    @(posedge core_clk_i);
    pattern      <= p;
    comparator_i <= c;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk_pin("window,output", {e[ST_WINDOW_BIT], e[ST_CMP_OUT_BIT]},
            {blanking_window_o, blanked_comparator_o});
    bus(1'b0, STATUS_OFFSET, 4'h3, 32'h0000_0000, q);
    chk_reg("status", 32'(e), q);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // About twelve times the expected run length
  initial begin
    repeat (40000) @(posedge core_clk_i);
    n_errors++;
    final_report();
  end

  initial begin
    logic [31:0] q, r;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, SRC_SELECT_OFFSET, 4'h3, 32'h0000_0000, q);
    chk_reg("source reset", {16'h0000, SRC_SELECT_RESET}, q);
    bus(1'b0, GATE_CONTROL_OFFSET, 4'h3, 32'h0000_0000, q);
    chk_reg("gate reset", {16'h0000, GATE_CONTROL_RESET}, q);
    bus(1'b1, GATE_CONTROL_OFFSET, 4'h3, 32'hFFFF_FFFF, q);
    bus(1'b1, GATE_CONTROL_OFFSET, 4'h1, 32'h0000_0000, q);
    bus(1'b1, 4'hC, 4'h3, 32'hFFFF_FFFF, q);
    bus(1'b1, STATUS_OFFSET, 4'h3, 32'hFFFF_FFFF, q);
    bus(1'b0, GATE_CONTROL_OFFSET, 4'h3, 32'h0000_0000, q);
    chk_reg("gate lanes", 32'h0000_BF00, q);
    bus(1'b1, SRC_SELECT_OFFSET, 4'h3, 32'hFFFF_FFFF, q);
    bus(1'b1, SRC_SELECT_OFFSET, 4'h2, 32'h0000_A5A5, q);
    bus(1'b0, SRC_SELECT_OFFSET, 4'h3, 32'h0000_0000, q);
    chk_reg("source bits", 32'h0000_05FF, q);
    bus(1'b0, 4'hC, 4'h3, 32'h0000_0000, q);
    chk_reg("unmapped", 32'h0000_0000, q);
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 16; c++) begin
        apply(16'(c) << (4 * m), 16'h0200 << (2 * m),
              c[0] ? 16'h0001 << c : ~(16'h0001 << c), 1'b1);
      end
    end
    $display("test sources done");
    for (int i = 0; i < 200; i++) begin
      q = next_rand();
      r = next_rand();
      apply(q[15:0], i < 8 ? corners[i] : q[31:16], r[15:0], r[16]);
    end
    $display("test random done");
    final_report();
  end
endmodule // test_comparator_blanking
